// File: rtl/dofm_monitor.sv
// Dual oscillator frequency monitor with selectable fault response
// Function
// (R1) Two oscillators cross-check each other's frequency continuously.
// (R2) Interface clock too fast sets over flag; too slow sets under flag.
// (R3) Comparison runs always except during self-test; no error then.
// (R4) Three-bit response mode with six legal values picks the reaction.
// (R5) Mode writes during an error are stored, applied after error ends and flags clear.
// (R6) Mode 000 is default: detection off, diag high, everything keeps running.
// (R7) Non-zero mode: any flag pulls diag low and holds it; 001 only reports.
// (R8) Controller clears flags serially; device then returns diag high.
// (R9) Clear accepted only if the latest comparison was within band.
// (R10) Mode 010 out of range: pre-drivers and relays low, pump runs.
// (R11) Mode 011 out of range: only pre-drivers low.
// (R12) Mode 100 out of range: pre-drivers, relays low and pump stopped.
// (R13) Mode 101: all off while any flag is set, even after recovery.
// (R14) Count one oscillator over a window of the other, compare with limits.
`include "dofm_defs.svh"
`default_nettype none
module dofm_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire logic interfaceOscIn,
  input wire logic bistActive,
  input wire logic modeWrite,
  input wire logic [`DOFM_MODE_W-1:0] modeWriteData,
  input wire logic flagClear,
  output logic overFrequencyFlag,
  output logic underFrequencyFlag,
  output logic diagFaultN,
  output logic preDriverEn,
  output logic relayEn,
  output logic chargePumpEn,
  output logic [`DOFM_MODE_W-1:0] freqErrorResponseMode,
  output logic modePending,
  output logic outOfBand
);

  dofm_cmp_if cmpBus ();

  dofm_pkg::dofm_state_type st_r;
  dofm_pkg::dofm_state_type st_nxt;

  logic anyFlag;
  logic fault;
  logic cutDrv;
  logic cutRly;
  logic cutPump;
  logic clearOk;
  logic setOver;
  logic setUnder;
  logic newOutOfBand;

  function automatic logic modeLegal(input logic [`DOFM_MODE_W-1:0] m);
    modeLegal = (m <= `DOFM_MODE_ALL_HOLD);
  endfunction

  function automatic logic modeIs(input logic [`DOFM_MODE_W-1:0] m,
                                  input logic [`DOFM_MODE_W-1:0] code);
    modeIs = (m == code);
  endfunction

  assign cmpBus.oscIn = interfaceOscIn;
  assign cmpBus.bistActive = bistActive;

  dofm_freq_cmp u_cmp (
    .clk(clk),
    .resetn(resetn),
    .cmpBus(cmpBus)
  );

  always_comb begin
    st_nxt = st_r;
    anyFlag = 1'b0;
    fault = 1'b0;
    cutDrv = 1'b0;
    cutRly = 1'b0;
    cutPump = 1'b0;
    clearOk = 1'b0;
    setOver = 1'b0;
    setUnder = 1'b0;
    newOutOfBand = st_r.outOfBand;

    // Latest comparison result, held between windows (see R1)
    if (cmpBus.done) begin
      newOutOfBand = cmpBus.tooFast | cmpBus.tooSlow;
    end
    // No error is raised while self-test runs (see R3)
    if (bistActive) begin
      newOutOfBand = 1'b0;
    end
    st_nxt.outOfBand = newOutOfBand;

    // Mode 000 disables detection, so nothing sets the flags (see R6)
    if (!modeIs(st_r.activeMode, `DOFM_MODE_OFF) && !bistActive) begin
      setOver = cmpBus.done & cmpBus.tooFast; // see R2
      setUnder = cmpBus.done & cmpBus.tooSlow; // see R2
    end

    // Clear is refused while the latest window is out of band (see R9)
    clearOk = flagClear & ~newOutOfBand;
    // Set wins over a clear landing in the same cycle (see R8)
    if (clearOk) begin
      st_nxt.overFreq = 1'b0;
      st_nxt.underFreq = 1'b0;
    end
    if (setOver) begin
      st_nxt.overFreq = 1'b1;
    end
    if (setUnder) begin
      st_nxt.underFreq = 1'b1;
    end

    // Only the six legal codes are stored; others are dropped (see R4)
    if (modeWrite && modeLegal(modeWriteData)) begin
      st_nxt.pendingMode = modeWriteData; // see R5
    end
    // Applied once the error is over and both flags are clear (see R5)
    if (!newOutOfBand && !st_nxt.overFreq && !st_nxt.underFreq) begin
      st_nxt.activeMode = st_nxt.pendingMode;
    end
    st_nxt.modePending = (st_nxt.pendingMode != st_nxt.activeMode);

    anyFlag = st_nxt.overFreq | st_nxt.underFreq;
    // Response uses the mode in force, not a write still waiting
    fault = newOutOfBand & ~modeIs(st_r.activeMode, `DOFM_MODE_OFF);

    case (st_r.activeMode)
      `DOFM_MODE_DRV_RLY: begin
        cutDrv = fault; // see R10
        cutRly = fault; // see R10
      end
      `DOFM_MODE_DRV: begin
        cutDrv = fault; // see R11
      end
      `DOFM_MODE_ALL: begin
        cutDrv = fault; // see R12
        cutRly = fault; // see R12
        cutPump = fault; // see R12
      end
      `DOFM_MODE_ALL_HOLD: begin
        // Latched off until software clears, trading uptime for safety
        cutDrv = anyFlag | fault; // see R13
        cutRly = anyFlag | fault; // see R13
        cutPump = anyFlag | fault; // see R13
      end
      default: begin
        // Modes 000 and 001 leave the drivers alone (see R6) (see R7)
        cutDrv = 1'b0;
      end
    endcase

    // Diag low while any flag is set, high again after clear (see R7) (see R8)
    st_nxt.diagFaultN = ~anyFlag;
    st_nxt.preDriverEn = ~cutDrv;
    st_nxt.relayEn = ~cutRly;
    st_nxt.chargePumpEn = ~cutPump;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{pendingMode: `DOFM_MODE_RESET, activeMode: `DOFM_MODE_RESET,
                outOfBand: 1'b0, overFreq: 1'b0, underFreq: 1'b0,
                diagFaultN: 1'b1, preDriverEn: 1'b1, relayEn: 1'b1,
                chargePumpEn: 1'b1, modePending: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign overFrequencyFlag = st_r.overFreq;
  assign underFrequencyFlag = st_r.underFreq;
  assign diagFaultN = st_r.diagFaultN;
  assign preDriverEn = st_r.preDriverEn;
  assign relayEn = st_r.relayEn;
  assign chargePumpEn = st_r.chargePumpEn;
  assign freqErrorResponseMode = st_r.activeMode;
  assign modePending = st_r.modePending;
  assign outOfBand = st_r.outOfBand;

endmodule
`default_nettype wire

// File: shared/dofm_defs.svh
// Constants for the dual oscillator frequency monitor
`ifndef DOFM_DEFS_SVH
`define DOFM_DEFS_SVH

// Window length in safety clock cycles
`define DOFM_WINDOW_LEN 10'h100
`define DOFM_WINDOW_LAST 10'h0ff
`define DOFM_CNT_W 10
// Nominal count: interface oscillator at one quarter of the safety clock
`define DOFM_NOM_COUNT 10'h040
// Ratio limits around the nominal count, about 1.25 and 1/1.25
`define DOFM_UPPER_LIMIT 10'h050
`define DOFM_LOWER_LIMIT 10'h033
`define DOFM_CNT_ZERO 10'h000
`define DOFM_CNT_ONE 10'h001

// Response mode codes
`define DOFM_MODE_W 3
`define DOFM_MODE_OFF 3'h0
`define DOFM_MODE_DIAG 3'h1
`define DOFM_MODE_DRV_RLY 3'h2
`define DOFM_MODE_DRV 3'h3
`define DOFM_MODE_ALL 3'h4
`define DOFM_MODE_ALL_HOLD 3'h5
`define DOFM_MODE_RESET 3'h0

`endif

// File: shared/dofm_pkg.sv
// Types for the dual oscillator frequency monitor
`include "dofm_defs.svh"
`default_nettype none
package dofm_pkg;

  typedef enum logic [1:0] {
    CMP_COUNT = 2'b01,
    CMP_EVAL = 2'b10
  } dofm_cmp_phase_type;

  typedef struct packed {
    dofm_cmp_phase_type phase;
    logic [`DOFM_CNT_W-1:0] winCnt;
    logic [`DOFM_CNT_W-1:0] edgeCnt;
    logic oscPrev;
    logic done;
    logic tooFast;
    logic tooSlow;
  } dofm_cmp_state_type;

  typedef struct packed {
    logic [`DOFM_MODE_W-1:0] pendingMode;
    logic [`DOFM_MODE_W-1:0] activeMode;
    logic outOfBand;
    logic overFreq;
    logic underFreq;
    logic diagFaultN;
    logic preDriverEn;
    logic relayEn;
    logic chargePumpEn;
    logic modePending;
  } dofm_state_type;

endpackage
`default_nettype wire

// File: shared/dofm_cmp_if.sv
// Interface between the monitor core and its window comparator
`default_nettype none
interface dofm_cmp_if;
  logic oscIn;
  logic bistActive;
  logic done;
  logic tooFast;
  logic tooSlow;

  modport core (
    output oscIn,
    output bistActive,
    input done,
    input tooFast,
    input tooSlow
  );

  modport cmp (
    input oscIn,
    input bistActive,
    output done,
    output tooFast,
    output tooSlow
  );
endinterface
`default_nettype wire

// File: rtl/dofm_freq_cmp.sv
// Window comparator counting interface oscillator edges on the safety clock
`include "dofm_defs.svh"
`default_nettype none
module dofm_freq_cmp (
  input wire logic clk,
  input wire logic resetn,
  dofm_cmp_if.cmp cmpBus
);

  dofm_pkg::dofm_cmp_state_type st_r;
  dofm_pkg::dofm_cmp_state_type st_nxt;

  logic oscRise;

  assign oscRise = cmpBus.oscIn & ~st_r.oscPrev;

  always_comb begin
    st_nxt = st_r;
    st_nxt.oscPrev = cmpBus.oscIn;
    st_nxt.done = 1'b0;
    case (st_r.phase)
      dofm_pkg::CMP_COUNT: begin
        // Edges counted over a fixed window of safety clock cycles (see R14)
        if (oscRise) begin
          st_nxt.edgeCnt = st_r.edgeCnt + `DOFM_CNT_ONE;
        end
        st_nxt.winCnt = st_r.winCnt + `DOFM_CNT_ONE;
        if (st_r.winCnt == `DOFM_WINDOW_LAST) begin
          st_nxt.phase = dofm_pkg::CMP_EVAL;
        end
      end
      dofm_pkg::CMP_EVAL: begin
        // Fast interface side also means a slow safety side, so one window
        // serves both directions of the cross check (see R1)
        st_nxt.tooFast = st_r.edgeCnt >= `DOFM_UPPER_LIMIT; // see R2
        st_nxt.tooSlow = st_r.edgeCnt <= `DOFM_LOWER_LIMIT; // see R2
        st_nxt.done = 1'b1;
        st_nxt.edgeCnt = `DOFM_CNT_ZERO;
        st_nxt.winCnt = `DOFM_CNT_ZERO;
        st_nxt.phase = dofm_pkg::CMP_COUNT;
      end
      default: begin
        st_nxt.phase = dofm_pkg::CMP_COUNT;
        st_nxt.winCnt = `DOFM_CNT_ZERO;
        st_nxt.edgeCnt = `DOFM_CNT_ZERO;
      end
    endcase
    // Self-test restarts the window so no stale count is judged (see R3)
    if (cmpBus.bistActive) begin
      st_nxt.phase = dofm_pkg::CMP_COUNT;
      st_nxt.winCnt = `DOFM_CNT_ZERO;
      st_nxt.edgeCnt = `DOFM_CNT_ZERO;
      st_nxt.done = 1'b0;
      st_nxt.tooFast = 1'b0;
      st_nxt.tooSlow = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{phase: dofm_pkg::CMP_COUNT, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cmpBus.done = st_r.done;
  assign cmpBus.tooFast = st_r.tooFast;
  assign cmpBus.tooSlow = st_r.tooSlow;

endmodule
`default_nettype wire

// File: rtl/dofm_cmp_if_dummy_placeholder_removed.sv
// Intentionally empty design unit holder
`default_nettype none
`default_nettype wire

// File: test/dofm_osc_model.sv
// Free-running interface oscillator model driven into the monitor
`default_nettype none
module dofm_osc_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] period,
  output logic oscOut
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] phase_r;
  // Never stops between windows, a real oscillator runs free
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_r <= 4'h0;
    end else if (phase_r >= period - 4'h1) begin
      phase_r <= 4'h0;
    end else begin
      phase_r <= phase_r + 4'h1;
    end
  end
  assign oscOut = phase_r < {1'h0, period[3:1]};
endmodule
`default_nettype wire

// File: test/dofm_monitor_chk.sv
// Port checker for the frequency monitor
`include "dofm_defs.svh"
`default_nettype none
module dofm_monitor_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic interfaceOscIn,
  input wire logic bistActive,
  input wire logic modeWrite,
  input wire logic [`DOFM_MODE_W-1:0] modeWriteData,
  input wire logic flagClear,
  input wire logic overFrequencyFlag,
  input wire logic underFrequencyFlag,
  input wire logic diagFaultN,
  input wire logic preDriverEn,
  input wire logic relayEn,
  input wire logic chargePumpEn,
  input wire logic [`DOFM_MODE_W-1:0] freqErrorResponseMode,
  input wire logic modePending,
  input wire logic outOfBand
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic anyF = overFrequencyFlag | underFrequencyFlag;
  wire logic [2:0] md = freqErrorResponseMode;
  wire logic [2:0] en = {preDriverEn, relayEn, chargePumpEn};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence sClearOk;
    flagClear ##1 !outOfBand;
  endsequence
  sequence sClearBad;
    flagClear && anyF ##1 outOfBand;
  endsequence
  // Outputs follow the mode in force one edge earlier, hence $past
  AST_DIAG: assert property (diagFaultN == !anyF)
    else $error("diag mismatch");
  AST_OFF: assert property (md == 3'h0 && !modeWrite && !anyF |=> !anyF)
    else $error("off flag");
  AST_SET: assert property ($past(md) != 3'h0 && outOfBand |-> anyF)
    else $error("no flag");
  AST_CLR_OK: assert property (sClearOk |-> !anyF && diagFaultN)
    else $error("clear lost");
  AST_CLR_BAD: assert property (sClearBad |-> anyF)
    else $error("clear taken");
  AST_BIST: assert property (bistActive |=> !outOfBand)
    else $error("bist band");
  AST_PEND: assert property (modeWrite && modeWriteData <= 3'h5 && modeWriteData != md
    && anyF && !flagClear |=> modePending && $stable(md)) else $error("mode not held");
  AST_M2: assert property ($past(md) == 3'h2 |-> en == {{2{!outOfBand}}, 1'h1})
    else $error("m2");
  AST_M3: assert property ($past(md) == 3'h3 |-> en == {!outOfBand, 2'h3})
    else $error("m3");
  AST_M4: assert property ($past(md) == 3'h4 |-> en == {3{!outOfBand}})
    else $error("m4");
  AST_M5: assert property ($past(md) == 3'h5 |-> en == {3{!(anyF || outOfBand)}})
    else $error("m5");
endmodule
bind dofm_monitor dofm_monitor_chk dofm_monitor_chk_i (.clk, .resetn, .interfaceOscIn,
  .bistActive, .modeWrite, .modeWriteData, .flagClear, .overFrequencyFlag, .underFrequencyFlag,
  .diagFaultN, .preDriverEn, .relayEn, .chargePumpEn, .freqErrorResponseMode, .modePending,
  .outOfBand);
`default_nettype wire

// File: test/dofm_monitor_tb.sv
// Self-checking bench for the frequency monitor
`default_nettype none
module dofm_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, resetn = 1'h0, bistActive = 1'h0, modeWrite = 1'h0, flagClear = 1'h0;
  logic [2:0] modeWriteData = 3'h0;
  logic [3:0] oscPeriod = 4'h4;
  logic interfaceOscIn, overFrequencyFlag, underFrequencyFlag, diagFaultN, preDriverEn;
  logic relayEn, chargePumpEn, modePending, outOfBand;
  logic [2:0] freqErrorResponseMode;
  int bad_count = 0;
  int samples_checked = 0;
  // Rows: mode, oscillator period (4 is nominal), flags/diag/enables during the fault
  logic [2:0] modeTab [8] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h4, 3'h5};
  logic [3:0] perTab [8] = '{4'h3, 4'h3, 4'h6, 4'h3, 4'h3, 4'h6, 4'h3, 4'h3};
  logic [5:0] expTab [8] = '{6'h0f, 6'h27, 6'h17, 6'h21, 6'h23, 6'h10, 6'h20, 6'h20};
  wire logic [5:0] outs = {overFrequencyFlag, underFrequencyFlag, diagFaultN, preDriverEn,
    relayEn, chargePumpEn};
  dofm_osc_model dofm_osc_model_i (.clk, .resetn, .period(oscPeriod), .oscOut(interfaceOscIn));
  dofm_monitor dofm_monitor_i (.clk, .resetn, .interfaceOscIn, .bistActive, .modeWrite,
    .modeWriteData, .flagClear, .overFrequencyFlag, .underFrequencyFlag, .diagFaultN,
    .preDriverEn, .relayEn, .chargePumpEn, .freqErrorResponseMode, .modePending, .outOfBand);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    // Looks happen mid-cycle, never in the step of a launching edge
    @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle pulses launched on a rising edge, taken on the next one
  task automatic req(input logic w, input logic c, input logic [2:0] m);
    @(posedge clk);
    modeWrite <= w;
    flagClear <= c;
    modeWriteData <= m;
    @(posedge clk);
    modeWrite <= 1'h0;
    flagClear <= 1'h0;
    tick(1);
  endtask
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    forever #10 clk = ~clk;
  end
  // About 13k cycles expected
  initial begin
    tick(30000);
    bad_count++;
    print_verdict();
  end
  // 600 cycles covers two full comparison windows
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    tick(600);
    chk({2'h0, outs}, 8'h0f);
    chk({4'h0, modePending, freqErrorResponseMode}, 8'h00);
    for (int i = 0; i < 8; i++) begin
      req(1'h1, 1'h0, modeTab[i]);
      chk({5'h0, freqErrorResponseMode}, {5'h0, modeTab[i]});
      oscPeriod <= perTab[i];
      tick(600);
      chk({2'h0, outs}, {2'h0, expTab[i]});
      req(1'h0, 1'h1, 3'h0);
      chk({2'h0, outs}, {2'h0, expTab[i]});
      oscPeriod <= 4'h4;
      tick(600);
      chk({2'h0, outs}, {2'h0, expTab[i][5:3], (modeTab[i] == 3'h5) ? 3'h0 : 3'h7});
      req(1'h0, 1'h1, 3'h0);
      chk({2'h0, outs}, 8'h0f);
      $display("Row %0d done", i);
    end
    oscPeriod <= 4'h3;
    tick(600);
    req(1'h1, 1'h0, 3'h1);
    chk({4'h0, modePending, freqErrorResponseMode}, 8'h0d);
    oscPeriod <= 4'h4;
    tick(600);
    req(1'h0, 1'h1, 3'h0);
    chk({4'h0, modePending, freqErrorResponseMode}, 8'h01);
    req(1'h1, 1'h0, 3'h7);
    chk({5'h0, freqErrorResponseMode}, 8'h01);
    $display("Mode write test done");
    @(posedge clk);
    bistActive <= 1'h1;
    oscPeriod <= 4'h3;
    tick(600);
    chk({5'h0, outOfBand, overFrequencyFlag, underFrequencyFlag}, 8'h00);
    @(posedge clk);
    bistActive <= 1'h0;
    tick(600);
    chk({5'h0, outOfBand, overFrequencyFlag, underFrequencyFlag}, 8'h06);
    $display("Self-test gating done");
    @(posedge clk);
    resetn <= 1'h0;
    tick(2);
    chk({2'h0, outs}, 8'h0f);
    @(posedge clk);
    resetn <= 1'h1;
    tick(2);
    chk({4'h0, modePending, freqErrorResponseMode}, 8'h00);
    $display("Mid-run reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
